// ### logic/cms_pkg.sv
// constants for the clock monitor and clock select block
package cms_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] CFG_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h008;
	// control register fields
	localparam int EXT_ON_BIT = 0;
	localparam int INT_ON_BIT = 1;
	localparam int CSEL_BIT = 2;
	localparam int MON_ON_BIT = 3;
	localparam int MON_FLAG_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h02;
	// configuration register fields
	localparam int XTAL_EN_BIT = 0;
	localparam int SLOW_BIT = 1;
	localparam logic [1:0] CFG_RESET = 2'h0;
	// status register fields
	localparam int EXT_STABLE_BIT = 0;
	localparam int INT_STABLE_BIT = 1;
	localparam int EXT_OFF_BIT = 2;
	localparam int INT_OFF_BIT = 3;
	// dividers
	localparam int DIV4_W = 2;
	localparam int LONG_W = 12;
	localparam int STAB_SHORT_BIT = 3;
	localparam int STAB_LONG_BIT = 11;
	localparam logic [1:0] MISS_LIMIT = 2'h2;
	localparam logic [1:0] STABLE_MEAS = 2'h2;
	localparam int SW_OSC = 0;
	localparam int SW_TB = 1;
endpackage

// ### logic/cms_clock_monitor_and_select.sv
// clock monitor, reference dividers and glitch-free clock switches
`timescale 1ns/1ns
module cms_clock_monitor_and_select (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic internal_base_clock,
	input wire logic internal_clock,
	input wire logic external_clock,
	input wire logic loop_filter_stable,
	input wire logic stop_mode,
	output logic external_gen_enable_sig,
	output logic internal_gen_enable_sig,
	output logic amp_enable,
	output logic oscillator_output_pin_port_en,
	output logic osc_input_path_enable,
	output logic oscillator_input_pin_port_en,
	output logic external_ref_clock,
	output logic internal_ref_clock,
	output logic oscillator_out_clock,
	output logic timebase_clock,
	output logic watchdog_clock,
	output logic generator_out_clock
);
	logic [4:0] ctrl_q;
	logic [1:0] cfg_q;
	logic mf_armed_q;
	logic internal_base_clock_q, external_clock_q, internal_clock_q;
	logic [1:0] idiv_q, ediv_q;
	logic [11:0] long_q;
	logic stab_q, external_stable_flag_q, internal_stable_flag_q;
	logic external_ref_clock_q, internal_ref_clock_q;
	logic internal_inactive_q, external_inactive_q, iseen_q, eseen_q;
	logic [1:0] imiss_q, emiss_q, lfs_cnt_q;
	wire [1:0] sw_q;
	logic gen_q, osc_prev_q;
	logic amp_q, path_q;
	wire [1:0] sw_e_on;
	wire [1:0] sw_i_on;

	// bus decode
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;
	wire hit_ctrl = paddr == cms_pkg::CTRL_OFFSET;
	wire hit_cfg = paddr == cms_pkg::CFG_OFFSET;
	wire hit_stat = paddr == cms_pkg::STATUS_OFFSET;
	wire hit = hit_ctrl | hit_cfg | hit_stat;
	wire wr_ctrl = wr & hit_ctrl;
	wire ext_on = ctrl_q[cms_pkg::EXT_ON_BIT];
	wire int_on = ctrl_q[cms_pkg::INT_ON_BIT];
	wire cs = ctrl_q[cms_pkg::CSEL_BIT];
	wire monitor_on = ctrl_q[cms_pkg::MON_ON_BIT];
	wire mflag = ctrl_q[cms_pkg::MON_FLAG_BIT];
	wire xtal = cfg_q[cms_pkg::XTAL_EN_BIT];
	wire slow = cfg_q[cms_pkg::SLOW_BIT];
	wire ext_en = ext_on & ~stop_mode;
	wire int_en = int_on & ~stop_mode;

	// edges of the sampled source clocks
	wire internal_base_clock_fall = internal_base_clock_q & ~internal_base_clock;
	wire external_clock_fall = external_clock_q & ~external_clock;
	wire internal_clock_fall = internal_clock_q & ~internal_clock;
	wire idiv_step = internal_base_clock_fall & (idiv_q == 2'h3);
	wire ediv_step = external_clock_fall & (ediv_q == 2'h3);
	// unstable: long counter counts raw external edges
	wire long_step = ~external_stable_flag_q ? external_clock_fall : (slow ? idiv_step : ediv_step);
	wire stab_next = xtal ? long_q[cms_pkg::STAB_LONG_BIT] :
		long_q[cms_pkg::STAB_SHORT_BIT];
	wire stab_fall = stab_q & ~stab_next;
	// slow crystal: long divider sits on the base-clock side
	wire external_ref_clock_d = slow ? ediv_q[1] : long_q[cms_pkg::STAB_LONG_BIT];
	wire internal_ref_clock_d = slow ? long_q[cms_pkg::STAB_LONG_BIT] : idiv_q[1];
	wire external_ref_clock_rise = ~external_ref_clock_q & external_ref_clock_d;
	wire internal_ref_clock_rise = ~internal_ref_clock_q & internal_ref_clock_d;
	wire kill_e = monitor_on & external_inactive_q;
	wire kill_i = monitor_on & internal_inactive_q;
	wire [1:0] sw_sel = {ext_on, cs};

	// target clock must be stable with both generators on
	wire cs_new = pwdata[cms_pkg::CSEL_BIT];
	wire cs_ok = int_on & ext_on & (cs_new ? external_stable_flag_q : internal_stable_flag_q);
	wire mf_clr = wr_ctrl & mf_armed_q & ~pwdata[cms_pkg::MON_FLAG_BIT];
	wire mf_set = monitor_on & (internal_inactive_q | external_inactive_q);
	wire cs_d = kill_e ? 1'b0 : kill_i ? 1'b1 :
		(wr_ctrl & cs_ok) ? cs_new : cs;

	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata = ~hit ? 32'h0 :
		hit_ctrl ? {27'h0, ctrl_q} :
		hit_cfg ? {30'h0, cfg_q} :
		{28'h0, internal_inactive_q, external_inactive_q, internal_stable_flag_q, external_stable_flag_q};
	assign external_gen_enable_sig = ext_en;
	assign internal_gen_enable_sig = int_en;
	assign amp_enable = amp_q;
	assign oscillator_output_pin_port_en = ~amp_q;
	assign osc_input_path_enable = path_q;
	assign oscillator_input_pin_port_en = ~path_q;
	assign external_ref_clock = external_ref_clock_q;
	assign internal_ref_clock = internal_ref_clock_q;
	assign oscillator_out_clock = sw_q[cms_pkg::SW_OSC];
	assign timebase_clock = sw_q[cms_pkg::SW_TB];
	assign watchdog_clock = sw_q[cms_pkg::SW_TB];
	assign generator_out_clock = gen_q;

	// software registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_q <= cms_pkg::CTRL_RESET;
			cfg_q <= cms_pkg::CFG_RESET;
			mf_armed_q <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl_q[cms_pkg::EXT_ON_BIT] <= pwdata[cms_pkg::EXT_ON_BIT];
				ctrl_q[cms_pkg::INT_ON_BIT] <= pwdata[cms_pkg::INT_ON_BIT];
				ctrl_q[cms_pkg::MON_ON_BIT] <= pwdata[cms_pkg::MON_ON_BIT];
			end
			ctrl_q[cms_pkg::CSEL_BIT] <= cs_d;
			// a new event beats a clear in the same cycle
			ctrl_q[cms_pkg::MON_FLAG_BIT] <= mf_set | (mflag & ~mf_clr);
			if (wr & hit_cfg)
				cfg_q <= pwdata[1:0];
			if (mf_clr | ~mflag)
				mf_armed_q <= 1'b0;
			else if (rd & hit_ctrl)
				mf_armed_q <= 1'b1;
		end
	end

	// pin enables
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			amp_q <= 1'b0;
			path_q <= 1'b0;
		end
		else
		begin
			amp_q <= ext_en & xtal;
			path_q <= ext_en;
		end
	end

	// sampled clocks and the four-fold dividers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			internal_base_clock_q <= 1'b0;
			external_clock_q <= 1'b0;
			internal_clock_q <= 1'b0;
			idiv_q <= 2'h0;
			ediv_q <= 2'h0;
		end
		else
		begin
			internal_base_clock_q <= internal_base_clock;
			external_clock_q <= external_clock;
			internal_clock_q <= internal_clock;
			if (internal_base_clock_fall)
				idiv_q <= idiv_q + 2'h1;
			if (external_clock_fall)
				ediv_q <= ediv_q + 2'h1;
		end
	end

	// long divider, which is also the stabilization counter
	always_ff @(posedge clk)
	begin
		if (srst | ~ext_en)
		begin
			long_q <= 12'h000;
			stab_q <= 1'b0;
			external_stable_flag_q <= 1'b0;
		end
		else
		begin
			if (long_step)
				long_q <= long_q + 12'h001;
			stab_q <= stab_next;
			// losing the external clock reverts the counter to stabilization counting
			if (external_inactive_q)
				external_stable_flag_q <= 1'b0;
			else if (stab_fall)
				external_stable_flag_q <= 1'b1;
		end
	end

	// activity detectors
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			external_ref_clock_q <= 1'b0;
			internal_ref_clock_q <= 1'b0;
			iseen_q <= 1'b0;
			eseen_q <= 1'b0;
			imiss_q <= 2'h0;
			emiss_q <= 2'h0;
			internal_inactive_q <= 1'b0;
			external_inactive_q <= 1'b0;
		end
		else
		begin
			external_ref_clock_q <= external_ref_clock_d;
			internal_ref_clock_q <= internal_ref_clock_d;
			if (external_ref_clock_rise)
				iseen_q <= 1'b0;
			else if (~external_ref_clock_q & internal_base_clock_fall)
				iseen_q <= 1'b1;
			if (~external_ref_clock_q & internal_base_clock_fall)
				imiss_q <= 2'h0;
			else if (external_ref_clock_rise & ~iseen_q & (imiss_q != cms_pkg::MISS_LIMIT))
				imiss_q <= imiss_q + 2'h1;
			if (internal_ref_clock_rise)
				eseen_q <= 1'b0;
			else if (~internal_ref_clock_q & external_clock_fall)
				eseen_q <= 1'b1;
			if (~internal_ref_clock_q & external_clock_fall)
				emiss_q <= 2'h0;
			else if (internal_ref_clock_rise & ~eseen_q & (emiss_q != cms_pkg::MISS_LIMIT))
				emiss_q <= emiss_q + 2'h1;
			internal_inactive_q <= imiss_q == cms_pkg::MISS_LIMIT;
			external_inactive_q <= emiss_q == cms_pkg::MISS_LIMIT;
		end
	end

	// internal stable: filter stable on two consecutive base-clock samples
	always_ff @(posedge clk)
	begin
		if (srst | ~loop_filter_stable | ~int_en | internal_inactive_q)
		begin
			lfs_cnt_q <= 2'h0;
			internal_stable_flag_q <= 1'b0;
		end
		else if (internal_base_clock_fall)
		begin
			if (lfs_cnt_q != cms_pkg::STABLE_MEAS)
				lfs_cnt_q <= lfs_cnt_q + 2'h1;
			internal_stable_flag_q <= lfs_cnt_q + 2'h1 >= cms_pkg::STABLE_MEAS;
		end
	end

	// two glitch-free switches; each side waits for the other to let go
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gsw
			logic [1:0] ens_q, ins_q;
			logic out_q;
			wire want_e = kill_i | (sw_sel[g] & ~kill_e);
			assign sw_q[g] = out_q;
			assign sw_e_on[g] = ens_q[1];
			assign sw_i_on[g] = ins_q[1];
			always_ff @(posedge clk)
			begin
				if (srst)
				begin
					ens_q <= 2'h0;
					ins_q <= 2'h3;
				end
				else
				begin
					// a dead side has no edges to walk its own chain down
					if (kill_e)
						ens_q <= 2'h0;
					else if (external_clock_fall)
						ens_q <= {ens_q[0], want_e & ~ins_q[1]};
					if (kill_i)
						ins_q <= 2'h0;
					else if (internal_clock_fall)
						ins_q <= {ins_q[0], ~want_e & ~ens_q[1]};
				end
			end
			always_ff @(posedge clk)
			begin
				if (srst)
					out_q <= 1'b0;
				else
					out_q <= (external_clock & ens_q[1]) |
						(internal_clock & ins_q[1]);
			end
		end
	endgenerate

	// bus clock source, divide by two
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			osc_prev_q <= 1'b0;
			gen_q <= 1'b0;
		end
		else
		begin
			osc_prev_q <= sw_q[cms_pkg::SW_OSC];
			if (sw_q[cms_pkg::SW_OSC] & ~osc_prev_q)
				gen_q <= ~gen_q;
		end
	end

	AST_AMP: assert property (@(posedge clk) disable iff (srst)
		##1 amp_enable == $past(ext_en & xtal))
		else $error("amplifier enable wrong");
	AST_STAB_RESET: assert property (@(posedge clk) disable iff (srst)
		!ext_en |=> long_q == 12'h000 && !external_stable_flag_q)
		else $error("stabilization counter not reset");
	AST_EXTERNAL_STABLE_FLAG_SET: assert property (@(posedge clk) disable iff (srst)
		$rose(external_stable_flag_q) |-> $past(stab_q) && !$past(stab_next))
		else $error("external stable set without stab edge");
	AST_INTERNAL_INACTIVE: assert property (@(posedge clk) disable iff (srst)
		$rose(internal_inactive_q) |-> $past(imiss_q) == 2'h2)
		else $error("internal inactive without two misses");
	AST_INTERNAL_STABLE_FLAG_CLR: assert property (@(posedge clk) disable iff (srst)
		(!loop_filter_stable || !int_en || internal_inactive_q) |=> !internal_stable_flag_q)
		else $error("internal stable not cleared");
	AST_FORCE_CS: assert property (@(posedge clk) disable iff (srst)
		kill_e |=> !cs)
		else $error("select not forced internal");
	AST_BBM: assert property (@(posedge clk) disable iff (srst)
		!(sw_e_on[0] && sw_i_on[0]) && !(sw_e_on[1] && sw_i_on[1]))
		else $error("both switch sides enabled");
	AST_CS_GUARD: assert property (@(posedge clk) disable iff (srst)
		$changed(cs) && !$past(kill_e || kill_i) |-> $past(cs_ok))
		else $error("select changed while not allowed");
	AST_GEN_DIV: assert property (@(posedge clk) disable iff (srst)
		sw_q[0] && !osc_prev_q |=> gen_q != $past(gen_q))
		else $error("generator clock did not toggle");
endmodule

// ### testbench/cms_ext_source.sv
// external clock source model standing at the oscillator input pin
`timescale 1ns/1ns
module cms_ext_source #(
	parameter int HALF = 2
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic path_enable,
	input wire logic run,
	output logic external_clock = 1'b0
);
	int cnt_q = 0;
	// a dead source stops low, so the monitor sees at most one last falling edge
	always @(posedge clk)
	begin
		if (srst || !path_enable || !run)
		begin
			cnt_q <= 0;
			external_clock <= 1'b0;
		end
		else if (cnt_q == HALF - 1)
		begin
			cnt_q <= 0;
			external_clock <= !external_clock;
		end
		else
			cnt_q <= cnt_q + 1;
	end
endmodule

// ### testbench/test_clock_monitor_and_select.sv
// self-checking bench for the clock monitor and clock select block
`timescale 1ns/1ns
module test_clock_monitor_and_select;
	localparam logic [11:0] CT = cms_pkg::CTRL_OFFSET;
	localparam logic [11:0] CF = cms_pkg::CFG_OFFSET;
	localparam logic [11:0] ST = cms_pkg::STATUS_OFFSET;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, internal_base_clock, internal_clock;
	logic external_clock, external_gen_enable_sig, internal_gen_enable_sig;
	logic amp_enable, oscillator_output_pin_port_en, osc_input_path_enable;
	logic oscillator_input_pin_port_en, external_ref_clock;
	logic internal_ref_clock, oscillator_out_clock, timebase_clock;
	logic watchdog_clock, generator_out_clock, rerr;
	logic loop_filter_stable = 1'b0;
	logic stop_mode = 1'b0;
	logic run = 1'b1;
	logic irun = 1'b1;
	logic [3:0] ph = 4'h0;
	logic [7:0] prv = 8'h00;
	logic [31:0] rdat;
	int failures = 0;
	int comparisons = 0;
	int cyc = 0;
	int t0;
	int rises [8] = '{default: 0};
	int s [8];
	int d [8];
	wire logic [7:0] mon = {external_ref_clock, internal_ref_clock,
		watchdog_clock, internal_clock, external_clock,
		oscillator_out_clock, timebase_clock, generator_out_clock};

	// base clock undivided, so a low reference phase always spans one fall
	assign internal_clock = ph[2] & irun;
	assign internal_base_clock = ph[2] & irun;

	cms_clock_monitor_and_select cms_clock_monitor_and_select_inst (
		.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .internal_base_clock, .internal_clock,
		.external_clock, .loop_filter_stable, .stop_mode,
		.external_gen_enable_sig, .internal_gen_enable_sig, .amp_enable,
		.oscillator_output_pin_port_en, .osc_input_path_enable,
		.oscillator_input_pin_port_en, .external_ref_clock,
		.internal_ref_clock, .oscillator_out_clock, .timebase_clock,
		.watchdog_clock, .generator_out_clock
	);

	cms_ext_source #(.HALF(2)) cms_ext_source_inst (
		.clk, .srst, .path_enable(osc_input_path_enable), .run,
		.external_clock
	);

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		ph <= ph + 4'h1;
		prv <= mon;
		cyc <= cyc + 1;
		for (int i = 0; i < 8; i++)
			if (mon[i] && !prv[i])
				rises[i] <= rises[i] + 1;
		if (cyc == 6000)
		begin
			failures++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		comparisons++;
		if (a !== e)
		begin
			failures++;
			$display("FAIL t=%0t got %h exp %h", $time, a, e);
		end
	endtask

	// holds the whole request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask

	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, ST, 32'h0);
			n++;
		end
		while (rdat[b] !== v && n < 80);
		chk({31'h0, rdat[b]}, {31'h0, v});
	endtask

	task automatic pins(input logic [3:0] e);
		repeat (2) @(posedge clk);
		chk({28'h0, amp_enable, oscillator_output_pin_port_en,
			osc_input_path_enable, oscillator_input_pin_port_en}, {28'h0, e});
	endtask

	// rising edges per source over a window, after the switch settles
	task automatic measure();
		repeat (30) @(posedge clk);
		s = rises;
		repeat (128) @(posedge clk);
		foreach (d[i])
			d[i] = rises[i] - s[i];
	endtask

	function automatic logic [31:0] nr(input int a, input int b);
		return 32'((a - b <= 2) && (b - a <= 2));
	endfunction

	initial
	begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(CT, 32'h2);
		rd(CF, 32'h0);
		rd(ST, 32'h0);
		rd(12'h00C, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, ST, 32'hF);
		rd(ST, 32'h0);
		apb(1'b1, CF, 32'h1);
		apb(1'b1, CT, 32'h3);
		pins(4'hA);
		stop_mode <= 1'b1;
		pins(4'h5);
		chk({30'h0, external_gen_enable_sig, internal_gen_enable_sig}, 32'h0);
		stop_mode <= 1'b0;
		apb(1'b1, CT, 32'h2);
		apb(1'b1, CF, 32'h0);
		apb(1'b1, CT, 32'h3);
		t0 = cyc;
		pins(4'h6);
		apb(1'b1, CT, 32'h7);
		rd(CT, 32'h3);
		rd(ST, 32'h0);
		poll(cms_pkg::EXT_STABLE_BIT, 1'b1);
		chk(32'(cyc - t0 >= 60 && cyc - t0 < 110), 32'h1);
		loop_filter_stable <= 1'b1;
		poll(cms_pkg::INT_STABLE_BIT, 1'b1);
		apb(1'b1, CT, 32'h7);
		rd(CT, 32'h7);
		measure();
		chk(nr(d[2], d[3]), 32'h1);
		chk(nr(d[1], d[3]), 32'h1);
		chk(nr(d[5], d[1]), 32'h1);
		chk(nr(4 * d[6], d[4]), 32'h1);
		chk(nr(2 * d[0], d[2]), 32'h1);
		loop_filter_stable <= 1'b0;
		poll(cms_pkg::INT_STABLE_BIT, 1'b0);
		apb(1'b1, CT, 32'hF);
		run <= 1'b0;
		poll(cms_pkg::EXT_OFF_BIT, 1'b1);
		rd(ST, 32'h4);
		rd(CT, 32'h1B);
		measure();
		chk(nr(d[2], d[4]), 32'h1);
		chk(nr(d[1], d[4]), 32'h1);
		apb(1'b1, CT, 32'h13);
		rd(CT, 32'h13);
		apb(1'b1, CT, 32'h3);
		rd(CT, 32'h3);
		run <= 1'b1;
		poll(cms_pkg::EXT_OFF_BIT, 1'b0);
		apb(1'b1, CF, 32'h2);
		measure();
		chk(nr(4 * d[7], d[3]), 32'h1);
		apb(1'b1, CT, 32'hB);
		irun <= 1'b0;
		poll(cms_pkg::INT_OFF_BIT, 1'b1);
		rd(CT, 32'h1F);
		measure();
		chk(nr(d[2], d[3]), 32'h1);
		irun <= 1'b1;
		poll(cms_pkg::INT_OFF_BIT, 1'b0);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		measure();
		chk(nr(d[2], d[4]), 32'h1);
		chk(nr(d[1], d[4]), 32'h1);
		rd(CT, 32'h2);
		complete_run();
	end
endmodule
